// >>> inc/pag_pkg.sv
// Package with register map, field layout and reset values of the port block
package pag_pkg;
	localparam int PAG_W = 16;
	localparam int PAG_ADDR_W = 8;
	localparam int PAG_DATA_W = 32;
	// Word offsets on the bus (byte address = 4 * index)
	localparam logic [5:0] PAG_IDX_ASSIGN = 6'h00;
	localparam logic [5:0] PAG_IDX_DIR = 6'h01;
	localparam logic [5:0] PAG_IDX_DATA = 6'h02;
	localparam logic [5:0] PAG_IDX_OD = 6'h03;
	// Pins with open-drain select bits
	localparam logic [15:0] PAG_OD_MASK = 16'h00fa;
	localparam logic [15:0] PAG_ASSIGN_RST = 16'h0000;
	localparam logic [15:0] PAG_DIR_RST = 16'h0000;
	localparam logic [15:0] PAG_OD_RST = 16'h0000;
	localparam logic [15:0] PAG_PIN_OUT_RST = 16'h0000;
	localparam logic [15:0] PAG_PIN_OE_N_RST = 16'hffff;
	localparam logic [13:0] PAG_PERIPH_RST = 14'h0000;
	localparam logic [31:0] PAG_RDATA_RST = 32'h0000_0000;
	localparam int PAG_SYNC_STAGES = 2;
endpackage

// >>> verilog/pag_sync.sv
// Two-stage synchroniser for the sixteen pin levels
`timescale 1ns/1ps
module pag_sync
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Asynchronous pin levels in, synchronised levels out
	input wire logic [pag_pkg::PAG_W-1:0] async_in,
	output logic [pag_pkg::PAG_W-1:0] sync_out
);
	import pag_pkg::*;

	logic [PAG_W-1:0] meta_q;
	logic [PAG_W-1:0] meta_d;
	logic [PAG_W-1:0] stable_q;
	logic [PAG_W-1:0] stable_d;

	always_comb
	begin
		meta_d = async_in;
		stable_d = meta_q;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			meta_q <= '0;
			stable_q <= '0;
		end
		else
		begin
			meta_q <= meta_d;
			stable_q <= stable_d;
		end
	end

	assign sync_out = stable_q;
endmodule

// >>> verilog/pag_port.sv
// Sixteen-pin shared parallel port with general-purpose and peripheral pin functions
// Notes on behaviour
// RULE1 - Assignment bit 0 gives general-purpose pin, 1 gives peripheral pin, for all sixteen.
// RULE2 - General-purpose pin: direction 0 is input, direction 1 is output.
// RULE3 - Reset clears assignment and direction bits: all pins general-purpose inputs.
// RULE4 - Data write goes to output latch; output pins drive the latched value.
// RULE5 - Data read of an output pin returns the pin level, not the latch.
// RULE6 - Input pins still latch written data, do not drive, read the pin.
// RULE7 - Reset puts every pin driver in high impedance.
// RULE8 - Pin levels stay readable while pins serve a peripheral.
// RULE9 - Peripheral inputs not taken from their pin get their fixed default.
// RULE10 - Direction 0 pins 0-7 carry serial rx/tx 1-4; rx 1 and 2 default low.
// RULE11 - Direction 1 pins 4-7 carry TDM data; TDM rx default low, serial rx 3/4 undefined.
// RULE12 - Later silicon: direction 1 pins 0/1 carry serial 4 when pins 6/7 do not.
// RULE13 - Pins 8,10,12,14: clock/timer inputs or baud outputs; unsourced inputs take baud outputs.
// RULE14 - Pins 9,11,13,15: clocks 2,4,6,8 or timer outputs; clock 4 defaults to clock 8.
// RULE15 - Open-drain pin drives low actively and floats instead of driving high.
// RULE16 - Only bits 7..3 and 1 have open-drain selects; other bits read zero.
// RULE17 - Four read-write 16-bit registers; open-drain register cleared at reset.
// RULE18 - Data latch is not reset; undefined until software writes it.
// RULE19 - Assigned pins take driver value and enable from their peripheral; input routed back.
// RULE20 - Pin levels pass a two-stage synchroniser before reads and peripherals.
//
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module pag_port
#(
	parameter logic LATE_SILICON = 1'b1
)
(
	// Clock and reset
	input wire logic mclk,
	input wire logic reset,
	// Avalon-MM slave
	input wire logic [pag_pkg::PAG_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [pag_pkg::PAG_DATA_W-1:0] writedata,
	input wire logic [3:0] byteenable,
	output logic [pag_pkg::PAG_DATA_W-1:0] readdata,
	output logic waitrequest,
	// Port pins
	input wire logic [pag_pkg::PAG_W-1:0] pin_in,
	output logic [pag_pkg::PAG_W-1:0] pin_out,
	output logic [pag_pkg::PAG_W-1:0] pin_oe_n,
	// Peripheral outputs toward the pins
	input wire logic serial_tx_1,
	input wire logic serial_tx_2,
	input wire logic serial_tx_3,
	input wire logic serial_tx_4,
	input wire logic serial_tx_en_1,
	input wire logic serial_tx_en_2,
	input wire logic serial_tx_en_3,
	input wire logic serial_tx_en_4,
	input wire logic tdm_b_tx_data,
	input wire logic tdm_a_tx_data,
	input wire logic baud_gen_out_1,
	input wire logic baud_gen_out_2,
	input wire logic baud_gen_out_3,
	input wire logic baud_gen_out_4,
	input wire logic timer_out_1,
	input wire logic timer_out_2,
	input wire logic timer_out_3,
	input wire logic timer_out_4,
	// Peripheral inputs fed from pins or defaults
	output logic serial_rx_1,
	output logic serial_rx_2,
	output logic serial_rx_3,
	output logic serial_rx_4,
	output logic tdm_b_rx_data,
	output logic tdm_a_rx_data,
	output logic clock_pin_1,
	output logic clock_pin_2,
	output logic clock_pin_3,
	output logic clock_pin_4,
	output logic clock_pin_5,
	output logic clock_pin_6,
	output logic clock_pin_7,
	output logic clock_pin_8,
	output logic timer_in_1,
	output logic timer_in_2,
	output logic timer_in_3,
	output logic timer_in_4,
	output logic tdm_a_rx_clock,
	output logic tdm_a_tx_clock,
	output logic tdm_b_rx_clock,
	output logic tdm_b_tx_clock
);
	import pag_pkg::*;

	function automatic logic [15:0] pag_merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
		pag_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
	endfunction
	logic [PAG_W-1:0] pin_s;
	logic [5:0] idx;
	logic acc_wr;
	logic acc_rd;
	logic [15:0] assign_q, assign_d, dir_q, dir_d, od_q, od_d, data_q, data_d;
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic [15:0] pin_out_q, pin_out_d, pin_oe_n_q, pin_oe_n_d;
	logic [15:0] ded_val, ded_en;
	logic alt_ok;
	logic [15:0] src;
	logic [13:0] periph_q, periph_d;
	pag_sync u_sync
	(
		.mclk(mclk),
		.reset(reset),
		.async_in(pin_in),
		.sync_out(pin_s) // [RULE20]
	);
	assign idx = address[7:2];
	assign acc_wr = write && !wait_q;
	assign acc_rd = read && !wait_q;

	// Bus slave: one wait cycle, then accept
	always_comb
	begin
		assign_d = assign_q;
		dir_d = dir_q;
		od_d = od_q;
		data_d = data_q;
		wait_d = 1'b1;
		rdata_d = rdata_q;
		if (wait_q && (read || write))
		begin
			wait_d = 1'b0;
			rdata_d = PAG_RDATA_RST;
			if (read)
			begin
				unique case (idx)
					PAG_IDX_ASSIGN: rdata_d[15:0] = assign_q;
					PAG_IDX_DIR: rdata_d[15:0] = dir_q;
					PAG_IDX_DATA: rdata_d[15:0] = pin_s; // [RULE5] [RULE6] [RULE8]
					PAG_IDX_OD: rdata_d[15:0] = od_q; // [RULE16]
					default: rdata_d = PAG_RDATA_RST;
				endcase
			end
		end
		if (acc_wr)
		begin
			unique case (idx)
				PAG_IDX_ASSIGN: assign_d = pag_merge(assign_q, writedata[15:0], byteenable[1:0]); // [RULE17]
				PAG_IDX_DIR: dir_d = pag_merge(dir_q, writedata[15:0], byteenable[1:0]);
				PAG_IDX_DATA: data_d = pag_merge(data_q, writedata[15:0], byteenable[1:0]); // [RULE4] [RULE6]
				PAG_IDX_OD: od_d = pag_merge(od_q, writedata[15:0], byteenable[1:0]) & PAG_OD_MASK; // [RULE16]
				default: ;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			assign_q <= PAG_ASSIGN_RST; // [RULE3]
			dir_q <= PAG_DIR_RST; // [RULE3]
			od_q <= PAG_OD_RST; // [RULE17]
			wait_q <= 1'b1;
			rdata_q <= PAG_RDATA_RST;
		end
		else
		begin
			assign_q <= assign_d;
			dir_q <= dir_d;
			od_q <= od_d;
			wait_q <= wait_d;
			rdata_q <= rdata_d;
		end
	end
	// Output latch carries no reset
	always_ff @(posedge mclk)
	begin
		data_q <= data_d; // [RULE18]
	end

	// Serial 4 may move to pins 0/1 only when pins 6/7 do not carry it
	assign alt_ok = LATE_SILICON && !(assign_q[6] && !dir_q[6]) && !(assign_q[7] && !dir_q[7]); // [RULE12]
	assign src = assign_q & ~dir_q;
	// Pin drivers
	always_comb
	begin
		ded_val = '0;
		ded_en = '0;
		ded_val[1] = dir_q[1] ? serial_tx_4 : serial_tx_1; // [RULE10] [RULE12]
		ded_en[1] = dir_q[1] ? (alt_ok && serial_tx_en_4) : serial_tx_en_1; // [RULE19]
		ded_val[3] = serial_tx_2;
		ded_en[3] = !dir_q[3] && serial_tx_en_2;
		ded_val[4] = tdm_b_tx_data; // [RULE11]
		ded_en[4] = dir_q[4];
		ded_val[5] = serial_tx_3;
		ded_en[5] = !dir_q[5] && serial_tx_en_3;
		ded_val[6] = tdm_a_tx_data;
		ded_en[6] = dir_q[6];
		ded_val[7] = serial_tx_4;
		ded_en[7] = !dir_q[7] && serial_tx_en_4;
		ded_val[8] = baud_gen_out_1; // [RULE13]
		ded_val[10] = baud_gen_out_2;
		ded_val[12] = baud_gen_out_3;
		ded_val[14] = baud_gen_out_4;
		ded_val[9] = timer_out_1; // [RULE14]
		ded_val[11] = timer_out_2;
		ded_val[13] = timer_out_3;
		ded_val[15] = timer_out_4;
		ded_en[15:8] = dir_q[15:8];
		for (int i = 0; i < PAG_W; i++)
		begin
			pin_out_d[i] = assign_q[i] ? ded_val[i] : data_q[i]; // [RULE1] [RULE4]
			pin_oe_n_d[i] = !((assign_q[i] ? ded_en[i] : dir_q[i]) && !(od_q[i] && pin_out_d[i])); // [RULE2] [RULE15]
		end
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
		begin
			pin_out_q <= PAG_PIN_OUT_RST;
			pin_oe_n_q <= PAG_PIN_OE_N_RST; // [RULE7]
		end
		else
		begin
			pin_out_q <= pin_out_d;
			pin_oe_n_q <= pin_oe_n_d;
		end
	end
	// Peripheral inputs from pins or defaults
	always_comb
	begin
		periph_d[0] = src[0] && pin_s[0]; // [RULE9] [RULE10]
		periph_d[1] = src[2] && pin_s[2];
		periph_d[2] = src[4] && pin_s[4]; // [RULE11]
		if (src[6])
			periph_d[3] = pin_s[6];
		else
			periph_d[3] = assign_q[0] && dir_q[0] && alt_ok && pin_s[0]; // [RULE12]
		periph_d[4] = assign_q[5] && dir_q[5] && pin_s[5]; // [RULE11]
		periph_d[5] = assign_q[7] && dir_q[7] && pin_s[7];
		periph_d[6] = src[8] ? pin_s[8] : baud_gen_out_1; // [RULE13] [RULE19]
		periph_d[7] = src[9] && pin_s[9]; // [RULE14]
		periph_d[8] = src[10] ? pin_s[10] : baud_gen_out_2;
		periph_d[13] = src[15] && pin_s[15];
		periph_d[9] = src[11] ? pin_s[11] : periph_d[13]; // [RULE14]
		periph_d[10] = src[12] ? pin_s[12] : baud_gen_out_3;
		periph_d[11] = src[13] && pin_s[13];
		periph_d[12] = src[14] ? pin_s[14] : baud_gen_out_4;
	end

	always_ff @(posedge mclk or posedge reset)
	begin
		if (reset)
			periph_q <= PAG_PERIPH_RST;
		else
			periph_q <= periph_d;
	end
	assign readdata = rdata_q;
	assign waitrequest = wait_q;
	assign pin_out = pin_out_q;
	assign pin_oe_n = pin_oe_n_q;
	assign serial_rx_1 = periph_q[0];
	assign serial_rx_2 = periph_q[1];
	assign serial_rx_3 = periph_q[2];
	assign serial_rx_4 = periph_q[3];
	assign tdm_b_rx_data = periph_q[4];
	assign tdm_a_rx_data = periph_q[5];
	assign clock_pin_1 = periph_q[6];
	assign timer_in_1 = periph_q[6];
	assign tdm_a_rx_clock = periph_q[6];
	assign clock_pin_2 = periph_q[7];
	assign clock_pin_3 = periph_q[8];
	assign timer_in_2 = periph_q[8];
	assign tdm_a_tx_clock = periph_q[8];
	assign clock_pin_4 = periph_q[9];
	assign clock_pin_5 = periph_q[10];
	assign timer_in_3 = periph_q[10];
	assign clock_pin_6 = periph_q[11];
	assign tdm_b_rx_clock = periph_q[11];
	assign clock_pin_7 = periph_q[12];
	assign timer_in_4 = periph_q[12];
	assign clock_pin_8 = periph_q[13];
	assign tdm_b_tx_clock = periph_q[13];
	// Checks
	property p_gpio_in;
		@(posedge mclk) disable iff (reset)
		1'b1 |=> (($past(~assign_q & ~dir_q) & ~pin_oe_n) == 16'h0000);
	endproperty
	a_gpio_in: assert property (p_gpio_in) else $error("general-purpose input pin is driven"); // [RULE2]
	property p_gpio_out;
		@(posedge mclk) disable iff (reset)
		(~assign_q[2] && dir_q[2]) |=> (!pin_oe_n[2] && pin_out[2] == $past(data_q[2]));
	endproperty
	a_gpio_out: assert property (p_gpio_out) else $error("output pin does not drive latch"); // [RULE4]
	property p_od_high;
		@(posedge mclk) disable iff (reset)
		1'b1 |=> (($past(od_q) & ~pin_oe_n & pin_out) == 16'h0000);
	endproperty
	a_od_high: assert property (p_od_high) else $error("open-drain pin drives high"); // [RULE15]
	property p_od_mask;
		@(posedge mclk) disable iff (reset)
		(od_q & ~PAG_OD_MASK) == 16'h0000;
	endproperty
	a_od_mask: assert property (p_od_mask) else $error("open-drain bit set outside mask"); // [RULE16]
	property p_assign_wr;
		@(posedge mclk) disable iff (reset)
		(acc_wr && idx == PAG_IDX_ASSIGN && byteenable[1:0] == 2'h3) |=> assign_q == $past(writedata[15:0]);
	endproperty
	a_assign_wr: assert property (p_assign_wr) else $error("assignment write lost"); // [RULE17]
	property p_data_rd;
		@(posedge mclk) disable iff (reset)
		(acc_rd && idx == PAG_IDX_DATA) |-> readdata[15:0] == $past(pin_s);
	endproperty
	a_data_rd: assert property (p_data_rd) else $error("data read is not pin level"); // [RULE5]
	property p_wait;
		@(posedge mclk) disable iff (reset)
		$rose(read || write) |-> ##[0:1] !waitrequest;
	endproperty
	a_wait: assert property (p_wait) else $error("request not answered in time");
	property p_rx1_default;
		@(posedge mclk) disable iff (reset)
		!(assign_q[0] && !dir_q[0]) |=> !serial_rx_1;
	endproperty
	a_rx1_default: assert property (p_rx1_default) else $error("serial rx 1 not grounded"); // [RULE10]
	property p_clock_pin_4;
		@(posedge mclk) disable iff (reset)
		!(assign_q[11] && !dir_q[11]) |=> clock_pin_4 == clock_pin_8;
	endproperty
	a_clock_pin_4: assert property (p_clock_pin_4) else $error("clock 4 does not follow clock 8"); // [RULE14]
	property p_brg1;
		@(posedge mclk) disable iff (reset)
		!(assign_q[8] && !dir_q[8]) |=> clock_pin_1 == $past(baud_gen_out_1);
	endproperty
	a_brg1: assert property (p_brg1) else $error("clock 1 does not follow baud output"); // [RULE13]
	c_write: cover property (@(posedge mclk) disable iff (reset) acc_wr && idx == PAG_IDX_DATA);
	c_read: cover property (@(posedge mclk) disable iff (reset) acc_rd && idx == PAG_IDX_DATA);
	c_ded: cover property (@(posedge mclk) disable iff (reset) assign_q[1] && !pin_oe_n[1]);
	c_od: cover property (@(posedge mclk) disable iff (reset) od_q[3] && !pin_oe_n[3]);
endmodule

// >>> sim/pag_pin_model.sv
// Board side of the port pins: device drive, board drive and floating pins
`timescale 1ns/1ps
module pag_pin_model
(
	// Clock
	input wire logic mclk,
	// Device drive
	input wire logic [15:0] pin_out,
	input wire logic [15:0] pin_oe_n,
	// Board drive
	input wire logic [15:0] ext_val,
	input wire logic [15:0] ext_en,
	// Resolved levels
	output logic [15:0] pin_in
);
	logic [15:0] float_q = 16'h0000;
	// No pull-ups, so a released pin wanders
	always @(posedge mclk)
		float_q <= ~float_q;
	always_comb
		pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_en & ext_val) | (pin_oe_n & ~ext_en & float_q);
endmodule

// >>> sim/pag_port_tb.sv
// Self-checking bench for the shared sixteen-pin port
`timescale 1ns/1ps
module pag_port_tb;
	import pag_pkg::*;
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [7:0] address = 8'h00;
	logic [31:0] writedata = 32'h0000_0000;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic [15:0] pin_in, pin_out, pin_oe_n;
	logic [15:0] ext_val = 16'h0000;
	logic [15:0] ext_en = 16'hffff;
	logic [17:0] per = 18'h00000;
	logic serial_rx_1, serial_rx_2, serial_rx_3, serial_rx_4, tdm_b_rx_data, tdm_a_rx_data;
	logic clock_pin_1, clock_pin_2, clock_pin_3, clock_pin_4, clock_pin_5, clock_pin_6, clock_pin_7, clock_pin_8;
	logic timer_in_1, timer_in_2, timer_in_3, timer_in_4;
	logic tdm_a_rx_clock, tdm_a_tx_clock, tdm_b_rx_clock, tdm_b_tx_clock;
	wire serial_tx_1 = per[0], serial_tx_2 = per[1], serial_tx_3 = per[2], serial_tx_4 = per[3];
	wire serial_tx_en_1 = per[4], serial_tx_en_2 = per[5], serial_tx_en_3 = per[6], serial_tx_en_4 = per[7];
	wire tdm_b_tx_data = per[8], tdm_a_tx_data = per[9];
	wire baud_gen_out_1 = per[10], baud_gen_out_2 = per[11], baud_gen_out_3 = per[12], baud_gen_out_4 = per[13];
	wire timer_out_1 = per[14], timer_out_2 = per[15], timer_out_3 = per[16], timer_out_4 = per[17];
	wire [13:0] obs = {clock_pin_8, clock_pin_7, clock_pin_6, clock_pin_5, clock_pin_4, clock_pin_3, clock_pin_2,
		clock_pin_1, tdm_a_rx_data, tdm_b_rx_data, serial_rx_4, serial_rx_3, serial_rx_2, serial_rx_1};
	int error_cnt = 0;
	int comparisons = 0;
	int seed = int'(32'hec26b860);
	int m;
	logic [15:0] dir, od, dat, out, drv, lvl;
	logic [31:0] rd;

	pag_port #(.LATE_SILICON(1'b1)) uut (.*);
	pag_pin_model board (.*);

	always #2 mclk = ~mclk;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wrap_up();
		$display("errors %0d comparisons %0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// One Avalon transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [5:0] idx, input logic [15:0] wd);
		int n = 0;
		@(posedge mclk);
		address <= {idx, 2'b00};
		writedata <= {16'h0000, wd};
		write <= wr;
		read <= ~wr;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (waitrequest !== 1'b0 && n < 50);
		rd = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (n >= 50)
			chk(32'h1, 32'h0);
	endtask

	task automatic setup(input logic [15:0] p, input logic [15:0] d, input logic [15:0] o, input logic [15:0] v);
		bus(1'b1, PAG_IDX_DATA, v);
		bus(1'b1, PAG_IDX_OD, o);
		bus(1'b1, PAG_IDX_DIR, d);
		bus(1'b1, PAG_IDX_ASSIGN, p);
		// Pin drive, two sync stages and the peripheral register
		repeat (5) @(posedge mclk);
	endtask

	task automatic rst_chk();
		reset <= 1'b1;
		repeat (16) @(posedge mclk);
		chk(pin_oe_n, 16'hffff);
		chk(waitrequest, 1'b1);
		reset <= 1'b0;
		bus(1'b0, PAG_IDX_ASSIGN, 16'h0000);
		chk(rd, 32'h0);
		bus(1'b0, PAG_IDX_DIR, 16'h0000);
		chk(rd, 32'h0);
		bus(1'b0, PAG_IDX_OD, 16'h0000);
		chk(rd, 32'h0);
	endtask

	// Peripheral inputs: 0 general-purpose, 1 dedicated inputs, 2 dedicated outputs
	function automatic logic [13:0] exp_obs(input int md, input logic [15:0] l);
		logic [7:0] c;
		for (int i = 0; i < 4; i++)
		begin
			c[2*i] = per[10+i];
			c[2*i+1] = 1'b0;
		end
		if (md == 1)
			return {l[15:8], 2'b00, l[6], l[4], l[2], l[0]};
		if (md == 2)
			return {c, l[7], l[5], l[0], 3'b000};
		return {c, 6'h00};
	endfunction

	initial
	begin
		rst_chk();
		bus(1'b1, 6'h05, 16'hffff);
		bus(1'b0, 6'h05, 16'h0000);
		chk(rd, 32'h0);
		// Upper lane only: lower direction byte must keep its reset value
		byteenable <= 4'h2;
		bus(1'b1, PAG_IDX_DIR, 16'hffff);
		byteenable <= 4'hf;
		bus(1'b0, PAG_IDX_DIR, 16'h0000);
		chk(rd, 32'h0000_ff00);
		for (int i = 0; i < 30; i++)
		begin
			@(posedge mclk);
			ext_val <= 16'($random(seed));
			per <= 18'($random(seed));
			m = i % 3;
			dat = 16'($random(seed));
			od = (i < 3) ? 16'hffff : 16'($random(seed));
			dir = (m == 0) ? 16'($random(seed)) : ((m == 1) ? 16'h0000 : 16'hffff);
			setup((m == 0) ? 16'h0000 : 16'hffff, dir, od, dat);
			out = dat;
			drv = dir;
			if (m == 1)
			begin
				out = {8'h00, per[3], 1'b0, per[2], 1'b0, per[1], 1'b0, per[0], 1'b0};
				drv = {8'h00, per[7], 1'b0, per[6], 1'b0, per[5], 1'b0, per[4], 1'b0};
			end
			if (m == 2)
			begin
				// Pin 1 carries serial tx 4 while pins 6/7 are not serial
				out = {per[17], per[13], per[16], per[12], per[15], per[11], per[14], per[10], 1'b0, per[9], 1'b0,
					per[8], 2'h0, per[3], 1'b0};
				drv = {12'hff5, 2'h0, per[7], 1'b0};
			end
			drv = drv & ~(od & PAG_OD_MASK & out);
			lvl = (drv & out) | (~drv & ext_val);
			chk({16'h0000, pin_oe_n}, {16'h0000, ~drv});
			chk(pin_out & drv, out & drv);
			chk(obs, exp_obs(m, lvl));
			bus(1'b0, PAG_IDX_DATA, 16'h0000);
			chk(rd, {16'h0000, lvl});
			bus(1'b0, PAG_IDX_OD, 16'h0000);
			chk(rd, {16'h0000, od & PAG_OD_MASK});
		end
		@(posedge mclk);
		ext_val <= 16'h8040;
		per <= 18'h004ff;
		// Pins 6/7 hold serial 4, so pin 1 must stay released
		setup(16'h80c3, 16'h0003, 16'h0000, 16'h0000);
		chk(clock_pin_4, 1'b1);
		chk(clock_pin_8, 1'b1);
		chk(clock_pin_2, 1'b0);
		chk(timer_in_1, per[10]);
		chk(pin_oe_n[1], 1'b1);
		chk(serial_rx_4, 1'b1);
		rst_chk();
		wrap_up();
	end

	initial
	begin
		repeat (20000) @(posedge mclk);
		error_cnt++;
		$display("mismatch at %0t: watchdog expired", $time);
		wrap_up();
	end
endmodule
